//--- logic/vps_ctrl.sv
`timescale 1ns/1ns
// How it works
// [R1] below overvoltage and enabled: wait 15 ms, then soft-start the switch
// [R2] acknowledge goes low only once the switch is fully on
// [R3] overvoltage turns the switch off and releases acknowledge in any state
// [R4] overvoltage turn-off completes in under 100 ns
// [R5] after overvoltage clears with hysteresis, wait the recovery delay
// [R6] start-up delay elapses before the charge pump ramps the switch
// [R7] recovery is followed by the full soft start, never skipped
// [R8] overtemperature forces the switch off and acknowledge released until it clears
// [R9] below undervoltage lockout the switch is off, acknowledge released
// [R10] enable low turns switch on with ack low; high holds it off unless host mode is set
// [R11] in overvoltage the enable level is ignored
// [R12] system supplies the pull-up on the open-drain acknowledge line
// [R13] host mode decisions use the connector rail; past lockout the switch turns on
// [R14] acknowledge low only if enabled or in host mode, in range and switch on
// [R15] one internal clock drives all timers
// [R16] recovery delay is nominally 20 ms
// [R17] soft-start interval is nominally 25 ms
// [R18] any fault or disable mid-sequence aborts and restarts the full delay
// [R19] inputs synchronised, except the immediate overvoltage turn-off path
module vps_ctrl
  import vps_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES   = STARTUP_CYC,
  parameter int unsigned RECOV_CYCLES     = RECOV_CYC,
  parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // system side
  input  wire logic              switch_enable_n,
  output logic                   switch_on_ack_n_o,
  output logic                   switch_on_ack_n_oe,
  input  wire logic              switch_on_ack_n_i,
  // comparators
  input  wire vps_sense_t        sense,
  // switch drive
  output logic                   gate_on,
  output logic                   charge_pump_en,
  // register port
  input  wire vps_bus_req_t      bus,
  output logic [DATA_W-1:0]      rdata,
  // interrupt
  output logic                   irq
);

  logic        en_meta_r, en_sync_r;
  vps_sense_t  sn_meta_r, sn_sync_r;
  vps_state_t  state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic        cnt_done;
  logic        ovp_fast;
  logic        fault;
  logic        go;
  logic        host_mode_r;
  logic        ovp_latched_r;
  logic [EV_W-1:0] ev_st_r, ev_msk_r, ev_set;
  logic        on_d_r;

  // two-stage synchronisers; first stage read only by second
  always_ff @(posedge clk) begin // [R19]
    if (!rst_n) begin
      en_meta_r <= 1'b1;
      en_sync_r <= 1'b1;
      sn_meta_r <= '0;
      sn_sync_r <= '0;
    end else begin
      en_meta_r <= switch_enable_n;
      en_sync_r <= en_meta_r;
      sn_meta_r <= sense;
      sn_sync_r <= sn_meta_r;
    end
  end

  // raw comparator bypasses the synchroniser so the gate drops next edge (40 ns)
  assign ovp_fast = sense.ovp; // [R4] [R19]
  assign fault    = sn_sync_r.undervoltage_lockout | sn_sync_r.thermal_shutdown; // [R8] [R9] [R13]
  // host mode starts the start-up delay as soon as the connector rail passes lockout
  assign go       = !en_sync_r | host_mode_r; // [R10] [R13]
  assign cnt_done = (cnt_r == '0);

  // overvoltage held until the hysteresis comparator says it has cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ovp_latched_r <= 1'b0;
    end else if (ovp_fast) begin
      ovp_latched_r <= 1'b1; // [R3]
    end else if (sn_sync_r.ovp_clear) begin
      ovp_latched_r <= 1'b0; // [R5]
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VPS_OFF: begin
        if (!fault && go) begin
          state_nxt = VPS_STARTUP; // [R1] [R6]
        end
      end
      VPS_STARTUP: begin
        if (fault || !go) begin
          state_nxt = VPS_OFF; // [R18]
        end else if (cnt_done) begin
          state_nxt = VPS_SOFT; // [R6]
        end
      end
      VPS_RECOVER: begin
        if (fault || !go) begin
          state_nxt = VPS_OFF; // [R18]
        end else if (cnt_done) begin
          state_nxt = VPS_SOFT; // [R7]
        end
      end
      VPS_SOFT: begin
        if (fault || !go) begin
          state_nxt = VPS_OFF; // [R18]
        end else if (cnt_done) begin
          state_nxt = VPS_ON; // [R17]
        end
      end
      VPS_ON: begin
        if (fault || !go) begin
          state_nxt = VPS_OFF; // [R8] [R9] [R10]
        end
      end
      VPS_OVP: begin
        if (!ovp_latched_r) begin
          state_nxt = VPS_RECOVER; // [R5] [R11]
        end
      end
      default: state_nxt = VPS_OFF;
    endcase
    if (ovp_fast || ovp_latched_r) begin
      state_nxt = VPS_OVP; // [R3] [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= VPS_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one down-counter for all delays, loaded on every state entry
  always_ff @(posedge clk) begin // [R15]
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      case (state_nxt)
        VPS_STARTUP: cnt_r <= CNT_W'(STARTUP_CYCLES - 1); // [R1]
        VPS_RECOVER: cnt_r <= CNT_W'(RECOV_CYCLES - 1); // [R16]
        VPS_SOFT:    cnt_r <= CNT_W'(SOFTSTART_CYCLES - 1); // [R17]
        default:     cnt_r <= '0;
      endcase
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // outputs registered; the gate reads state_nxt so overvoltage drops it in one edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_on            <= 1'b0;
      charge_pump_en     <= 1'b0;
      switch_on_ack_n_oe <= 1'b0;
      switch_on_ack_n_o  <= 1'b0;
      on_d_r             <= 1'b0;
    end else begin
      // open drain: only ever drives low, the pull-up is external
      switch_on_ack_n_o  <= 1'b0; // [R12]
      gate_on            <= (state_nxt == VPS_SOFT) || (state_nxt == VPS_ON); // [R3] [R4]
      charge_pump_en     <= (state_nxt == VPS_SOFT) || (state_nxt == VPS_ON); // [R6]
      // ack driven low only in the fully-on state
      switch_on_ack_n_oe <= (state_nxt == VPS_ON); // [R2] [R14]
      on_d_r             <= (state_r == VPS_ON);
    end
  end

  // events for the interrupt status register
  always_comb begin
    ev_set             = '0;
    ev_set[EV_OVP]     = (state_nxt == VPS_OVP) && (state_r != VPS_OVP);
    ev_set[EV_THERMAL] = sn_sync_r.thermal_shutdown;
    ev_set[EV_UNDERVOLTAGE_LOCKOUT]    = sn_sync_r.undervoltage_lockout;
    ev_set[EV_ON]      = (state_r == VPS_ON) && !on_d_r;
  end

  // sticky status, write one to clear; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_st_r <= '0;
    end else if (bus.wr && bus.addr == ADDR_IRQ_ST) begin
      ev_st_r <= (ev_st_r & ~bus.wdata[EV_W-1:0]) | ev_set;
    end else begin
      ev_st_r <= ev_st_r | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_msk_r    <= MSK_RST;
      host_mode_r <= HOST_RST;
    end else if (bus.wr && bus.addr == ADDR_IRQ_MSK) begin
      ev_msk_r <= bus.wdata[EV_W-1:0];
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      host_mode_r <= bus.wdata[0]; // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_st_r & ev_msk_r);
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_STATUS:  rdata <= DATA_W'({switch_on_ack_n_i, ovp_latched_r, fault, en_sync_r,
                                        gate_on, state_r});
        ADDR_IRQ_ST:  rdata <= DATA_W'(ev_st_r);
        ADDR_IRQ_MSK: rdata <= DATA_W'(ev_msk_r);
        ADDR_CTRL:    rdata <= DATA_W'(host_mode_r);
        default:      rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule

//--- logic/vps_pkg.sv
package vps_pkg;

  // clock rate and documented times
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned STARTUP_MS      = 15;
  localparam int unsigned RECOV_MS        = 20;
  localparam int unsigned SOFTSTART_MS    = 25;
  localparam int unsigned OFF_LIMIT_NS    = 100;
  localparam int unsigned MS_PER_S        = 1000;

  // cycle counts, cycles per ms times ms (round down, no lower limit)
  localparam int unsigned STARTUP_CYC   = CLK_HZ / MS_PER_S * STARTUP_MS;
  localparam int unsigned RECOV_CYC     = CLK_HZ / MS_PER_S * RECOV_MS;
  localparam int unsigned SOFTSTART_CYC = CLK_HZ / MS_PER_S * SOFTSTART_MS;

  localparam int unsigned CNT_W = 20;

  // register map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h3;

  // interrupt status / mask bit positions
  localparam int unsigned EV_W       = 4;
  localparam int unsigned EV_OVP     = 0;
  localparam int unsigned EV_THERMAL = 1;
  localparam int unsigned EV_UNDERVOLTAGE_LOCKOUT    = 2;
  localparam int unsigned EV_ON      = 3;

  localparam logic [EV_W-1:0]   MSK_RST  = 4'h0;
  localparam logic              HOST_RST = 1'b0;

  typedef enum logic [2:0] {
    VPS_OFF      = 3'b000,
    VPS_STARTUP  = 3'b001,
    VPS_RECOVER  = 3'b010,
    VPS_SOFT     = 3'b011,
    VPS_ON       = 3'b100,
    VPS_OVP      = 3'b101
  } vps_state_t;

  // comparator indications, all active high
  typedef struct packed {
    logic ovp;
    logic ovp_clear;
    logic undervoltage_lockout;
    logic thermal_shutdown;
  } vps_sense_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } vps_bus_req_t;

endpackage

//--- tb/vps_ctrl_props.sv
`timescale 1ns/1ns
module vps_ctrl_props
  import vps_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES   = STARTUP_CYC,
  parameter int unsigned SOFTSTART_CYCLES = SOFTSTART_CYC
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // watched ports
  input wire logic       switch_enable_n,
  input wire logic       switch_on_ack_n_oe,
  input wire vps_sense_t sense,
  input wire logic       gate_on,
  input wire logic       charge_pump_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ovp_gate_off: assert property (sense.ovp |=> !gate_on)
    else $error("gate on after ovp");
  a_ovp_ack_rel: assert property (sense.ovp |=> !switch_on_ack_n_oe)
    else $error("ack held in ovp");
  a_ack_needs_gate: assert property (switch_on_ack_n_oe |-> gate_on)
    else $error("ack low with switch off");
  a_pump_with_gate: assert property (charge_pump_en == gate_on)
    else $error("pump and gate differ");
  a_undervoltage_lockout_off: assert property (sense.undervoltage_lockout [*5] |-> !gate_on && !switch_on_ack_n_oe)
    else $error("on in lockout");
  a_thermal_off: assert property (sense.thermal_shutdown [*5] |-> !gate_on)
    else $error("on in thermal");
  a_disable_rel: assert property (switch_enable_n [*5] |-> !switch_on_ack_n_oe)
    else $error("ack low while disabled");
  a_soft_span: assert property ($rose(switch_on_ack_n_oe) |->
    $past(gate_on, SOFTSTART_CYCLES - 1) && !$past(gate_on, SOFTSTART_CYCLES + 2))
    else $error("soft start span wrong");
  a_start_wait: assert property ($rose(gate_on) |-> $past(!gate_on, STARTUP_CYCLES - 1))
    else $error("switch on before delay");
  cover property ($rose(switch_on_ack_n_oe));
  cover property (sense.ovp && gate_on);
  cover property (sense.undervoltage_lockout && gate_on);
endmodule

bind vps_ctrl vps_ctrl_props #(
  .STARTUP_CYCLES  (STARTUP_CYCLES),
  .SOFTSTART_CYCLES(SOFTSTART_CYCLES)
) u_props (.clk(clk), .rst_n(rst_n), .switch_enable_n(switch_enable_n),
  .switch_on_ack_n_oe(switch_on_ack_n_oe), .sense(sense), .gate_on(gate_on),
  .charge_pump_en(charge_pump_en));

//--- tb/vps_sys_model.sv
`timescale 1ns/1ns
module vps_sys_model (
  // clock and bench request
  input  wire logic clk,
  input  wire logic want_on,
  // device pins
  output logic      switch_enable_n,
  input  wire logic ack_o,
  input  wire logic ack_oe,
  output logic      ack_pin
);
  initial switch_enable_n = 1'b1;
  always @(posedge clk) switch_enable_n <= !want_on;
  // released line floats to the pull-up level
  assign ack_pin = ack_oe ? ack_o : 1'b1;
endmodule

//--- tb/vbus_protection_switch_control_bench.sv
`timescale 1ns/1ns
module vbus_protection_switch_control_bench;
  import vps_pkg::*;
  // short counts keep the run small
  localparam int ST = 20;
  localparam int RC = 30;
  localparam int SS = 40;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              want_on = 1'b0;
  logic              en_n, ack_o, ack_oe, ack_pin, gate_on, pump, irq;
  logic [DATA_W-1:0] rdata, d;
  vps_sense_t        sense = '0;
  vps_bus_req_t      bus = '0;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                seed = 32'h2757;
  int                n;
  always #20 clk = ~clk;
  vps_sys_model u_sys (.clk(clk), .want_on(want_on), .switch_enable_n(en_n), .ack_o(ack_o),
    .ack_oe(ack_oe), .ack_pin(ack_pin));
  vps_ctrl #(.STARTUP_CYCLES(ST), .RECOV_CYCLES(RC), .SOFTSTART_CYCLES(SS)) DUT (.clk(clk),
    .rst_n(rst_n), .switch_enable_n(en_n), .switch_on_ack_n_o(ack_o),
    .switch_on_ack_n_oe(ack_oe), .switch_on_ack_n_i(ack_pin), .sense(sense),
    .gate_on(gate_on), .charge_pump_en(pump), .bus(bus), .rdata(rdata), .irq(irq));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_span(input string nm, input int lo, input int g);
    n_compared++;
    if (g < lo || g > lo + 6) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, lo, g);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    d = rdata;
  endtask
  // counts edges until the switch (sel 0) or the acknowledge (sel 1) is on
  task wait_on(input bit sel, output int k);
    k = 0;
    while ((sel ? ~ack_pin : gate_on) !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("gate", 0, gate_on);
    rd(ADDR_IRQ_MSK);
    chk("mask", MSK_RST, d);
    want_on <= 1'b1;
    wait_on(0, n);
    chk_span("startup", ST, n);
    chk("pump", 1, pump);
    wait_on(1, n);
    chk_span("soft", SS - 2, n);
    rd(ADDR_STATUS);
    chk("status", 32'h4, {d[8], d[2:0]});
    $display("start test done");
    sense.ovp <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ovp gate", 0, gate_on);
    chk("ovp ack", 1, ack_pin);
    want_on <= 1'b0;
    repeat (6) @(posedge clk);
    want_on <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ovp en", 0, gate_on);
    rd(ADDR_IRQ_ST);
    chk("ovp event", 1, d[EV_OVP]);
    chk("irq masked", 0, irq);
    wr(ADDR_IRQ_MSK, 32'h1 << EV_OVP);
    @(posedge clk);
    chk("irq", 1, irq);
    wr(ADDR_IRQ_ST, 32'h1 << EV_OVP);
    @(posedge clk);
    chk("irq clear", 0, irq);
    wr(4'hA, $random(seed));
    rd(4'hA);
    chk("unmapped", 0, d);
    sense.ovp <= 1'b0;
    sense.ovp_clear <= 1'b1;
    wait_on(0, n);
    chk_span("recovery", RC, n);
    wait_on(1, n);
    chk_span("recov soft", SS - 2, n);
    $display("ovp test done");
    for (int f = 0; f < 2; f++) begin
      if (f == 0)
        sense.thermal_shutdown <= 1'b1;
      else
        sense.undervoltage_lockout <= 1'b1;
      repeat (6) @(posedge clk);
      chk("fault gate", 0, gate_on);
      chk("fault ack", 1, ack_pin);
      sense.thermal_shutdown <= 1'b0;
      sense.undervoltage_lockout <= 1'b0;
      wait_on(0, n);
      chk_span("restart", ST, n);
      wait_on(1, n);
    end
    $display("fault test done");
    want_on <= 1'b0;
    repeat (6) @(posedge clk);
    want_on <= 1'b1;
    repeat (4 + $unsigned($random(seed)) % (ST - 6)) @(posedge clk);
    want_on <= 1'b0;
    repeat (ST + 4) @(posedge clk);
    chk("abort", 0, gate_on);
    want_on <= 1'b1;
    wait_on(0, n);
    chk_span("full delay", ST, n);
    $display("abort test done");
    end_sim;
  end
endmodule
